// ==== rtl/paio_port.sv ====
// port a general-purpose io with alternate pin steering

`include "paio_cfg.svh"

module paio_port
  import paio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // port a pins
  input wire logic [7:0] port_a_pin_in,
  output paio_pin_drv_t port_a_pin_drv,
  // second capture/compare/pwm candidate pads
  input wire logic pad_c1_in,
  input wire logic pad_b3_in,
  output paio_pad_drv_t pad_c1_drv,
  output paio_pad_drv_t pad_b3_drv,
  // peripheral side, same clock
  input wire logic second_ccp_out,
  input wire logic second_ccp_oe,
  output logic second_ccp_in,
  output logic slave_select_in_b
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // address match, shared by every register decode
  function automatic logic reg_hit(input logic [4:0] addr,
                                   input logic [4:0] off);
    reg_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------

  logic [7:0] port_a_latch;
  logic [7:0] port_a_direction;
  logic [5:0] analog_select_bits;
  logic slave_select_route;
  logic second_ccp_route;
  paio_bus_state_t bus_state;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------

  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [1:0] pad_meta;
  logic [1:0] pad_sync;

  // pins are asynchronous to ref_clk; the first stage feeds only the
  // second, so a metastable sample never reaches decode logic
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pad_meta <= 2'h0;
      pad_sync <= 2'h0;
    end else begin
      pin_meta <= port_a_pin_in;
      pin_sync <= pin_meta;
      pad_meta <= {pad_b3_in, pad_c1_in};
      pad_sync <= pad_meta;
    end
  end

  // ----------------------------------------------------------------
  // per-pin input gating and driver enable
  // ----------------------------------------------------------------

  logic [7:0] pin_digital;
  logic [7:0] next_pin_enable;
  logic [7:0] analog_mask;

  // only the lower six pins carry an analog-select bit
  assign analog_mask = {2'b00, analog_select_bits};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      // input buffer off forces a zero, whatever the pad does
      assign pin_digital[g] = pin_sync[g] & ~analog_mask[g];
      // direction alone decides the driver, analog or not
      assign next_pin_enable[g] = ~port_a_direction[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  logic bus_req;
  logic bus_take;
  logic lane0;
  logic hit_data;
  logic hit_dir;
  logic hit_ansel;
  logic hit_alt;
  logic hit_set;
  logic hit_clr;
  logic hit_any;
  logic [7:0] wr_byte;

  assign bus_req = avs_read | avs_write;
  // a request is taken on the edge where waitrequest is seen low
  assign bus_take = bus_req & (bus_state == PAIO_BUS_ANSWER);
  assign lane0 = avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];

  assign hit_data = reg_hit(avs_address, `PAIO_OFF_DATA);
  assign hit_dir = reg_hit(avs_address, `PAIO_OFF_DIR);
  assign hit_ansel = reg_hit(avs_address, `PAIO_OFF_ANSEL);
  assign hit_alt = reg_hit(avs_address, `PAIO_OFF_ALT);
  assign hit_set = reg_hit(avs_address, `PAIO_OFF_SET);
  assign hit_clr = reg_hit(avs_address, `PAIO_OFF_CLR);
  assign hit_any = hit_data | hit_dir | hit_ansel | hit_alt |
                   hit_set | hit_clr;

  // write strobes; narrow registers live in byte lane 0 only
  logic wr_go;
  logic wr_data;
  logic wr_dir;
  logic wr_ansel;
  logic wr_alt;
  logic wr_set;
  logic wr_clr;

  assign wr_go = bus_take & avs_write & lane0;
  assign wr_data = wr_go & hit_data;
  assign wr_dir = wr_go & hit_dir;
  assign wr_ansel = wr_go & hit_ansel;
  assign wr_alt = wr_go & hit_alt;
  assign wr_set = wr_go & hit_set;
  assign wr_clr = wr_go & hit_clr;

  // ----------------------------------------------------------------
  // output latch update
  // ----------------------------------------------------------------

  logic [7:0] next_latch;

  // set and clear writes start from what the pins read now and
  // only touch masked bits, so an analog pin or a loaded output
  // that reads differently from its latch is rewritten with that
  // reading - the classic read-modify-write hazard, kept on purpose
  always_comb begin
    next_latch = port_a_latch;
    if (wr_data) begin
      next_latch = wr_byte;
    end else if (wr_set) begin
      next_latch = pin_digital | wr_byte;
    end else if (wr_clr) begin
      next_latch = pin_digital & ~wr_byte;
    end
  end

  // the latch has no meaningful reset value; zero keeps it defined
  // so a pin turned to output before any data write drives low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_latch <= `PAIO_RST_LATCH;
    end else begin
      port_a_latch <= next_latch;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------

  // the lower six pins wake as analog inputs; every pin wakes with its driver off
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_direction <= `PAIO_RST_DIR;
      analog_select_bits <= `PAIO_RST_ANSEL;
      {slave_select_route, second_ccp_route} <= `PAIO_RST_ALT;
    end else begin
      if (wr_dir) begin
        port_a_direction <= wr_byte;
      end
      if (wr_ansel) begin
        analog_select_bits <= wr_byte[`PAIO_ANSEL_W-1:0];
      end
      if (wr_alt) begin
        slave_select_route <= wr_byte[`PAIO_ALT_SS_BIT];
        second_ccp_route <= wr_byte[`PAIO_ALT_CCP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------

  logic [7:0] alt_read;
  logic [7:0] rd_byte;

  // unimplemented route bits read as zero
  always_comb begin
    alt_read = 8'h00;
    alt_read[`PAIO_ALT_SS_BIT] = slave_select_route;
    alt_read[`PAIO_ALT_CCP_BIT] = second_ccp_route;
  end

  // set and clear views read back the pins, like the data view
  assign rd_byte =
    (hit_data | hit_set | hit_clr) ? pin_digital :
    hit_dir ? port_a_direction :
    hit_ansel ? analog_mask :
    hit_alt ? alt_read :
    8'h00;

  // ----------------------------------------------------------------
  // avalon handshake
  // ----------------------------------------------------------------

  logic next_waitrequest;
  paio_bus_state_t next_bus_state;

  // one wait cycle per access: the request is seen, then waitrequest
  // drops for exactly one edge carrying the answer; this costs a
  // cycle but keeps every bus output straight off a flop; a master
  // that leaves its request up past the answer starts a second
  // access, so it must drop the request right after taking it
  always_comb begin
    next_bus_state = PAIO_BUS_IDLE;
    case (bus_state)
      PAIO_BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state = PAIO_BUS_ANSWER;
        end
      end
      PAIO_BUS_ANSWER: begin
        next_bus_state = PAIO_BUS_IDLE;
      end
      default: begin
        next_bus_state = PAIO_BUS_IDLE;
      end
    endcase
  end

  assign next_waitrequest = (next_bus_state != PAIO_BUS_ANSWER);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= PAIO_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= `PAIO_RESP_OK;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      if (bus_state == PAIO_BUS_IDLE && bus_req) begin
        // read data sampled one cycle before the taking edge
        avs_readdata <= {24'h000000, avs_read ? rd_byte : 8'h00};
        avs_response <= hit_any ? `PAIO_RESP_OK : `PAIO_RESP_ERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------

  // registered so each pad output comes off a flop; the analog
  // selection never enters this path
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_pin_drv <= '0;
    end else begin
      port_a_pin_drv.level <= port_a_latch;
      port_a_pin_drv.enable <= next_pin_enable;
    end
  end

  // ----------------------------------------------------------------
  // alternate pin steering
  // ----------------------------------------------------------------

  logic next_ss;
  logic next_ccp_in;
  paio_pad_drv_t ccp_drv;
  paio_pad_drv_t idle_drv;

  // slave select comes through the digital input path, so an
  // analog-selected candidate pin reads as asserted low
  assign next_ss = slave_select_route ?
                   pin_digital[`PAIO_SS_PIN_HIGH] :
                   pin_digital[`PAIO_SS_PIN_LOW];

  assign next_ccp_in = second_ccp_route ? pad_sync[1] :
                       pad_sync[0];

  assign ccp_drv = '{level: second_ccp_out, enable: second_ccp_oe};
  assign idle_drv = '{level: 1'b0, enable: 1'b0};

  // the unselected pad is released so it cannot fight its neighbour
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slave_select_in_b <= 1'b1;
      second_ccp_in <= 1'b0;
      pad_c1_drv <= '0;
      pad_b3_drv <= '0;
    end else begin
      slave_select_in_b <= next_ss;
      second_ccp_in <= next_ccp_in;
      pad_c1_drv <= second_ccp_route ? idle_drv : ccp_drv;
      pad_b3_drv <= second_ccp_route ? ccp_drv : idle_drv;
    end
  end

endmodule

// ==== rtl/paio_cfg.svh ====
// constants for the port a io block: offsets, fields, reset values
`ifndef PAIO_CFG_SVH
`define PAIO_CFG_SVH

// byte offsets on the register bus
`define PAIO_OFF_DATA 5'h00
`define PAIO_OFF_DIR 5'h04
`define PAIO_OFF_ANSEL 5'h08
`define PAIO_OFF_ALT 5'h0C
`define PAIO_OFF_SET 5'h10
`define PAIO_OFF_CLR 5'h14

// field positions in alternate_pin_select
`define PAIO_ALT_CCP_BIT 0
`define PAIO_ALT_SS_BIT 1

// pins that carry the slave-select candidates
`define PAIO_SS_PIN_LOW 5
`define PAIO_SS_PIN_HIGH 0

// reset values
`define PAIO_RST_DIR 8'hFF
`define PAIO_RST_ANSEL 6'h3F
`define PAIO_RST_ALT 2'h0
`define PAIO_RST_LATCH 8'h00

// implemented width of the analog-select field
`define PAIO_ANSEL_W 6

// avalon response codes
`define PAIO_RESP_OK 2'h0
`define PAIO_RESP_ERR 2'h2

`endif

// ==== rtl/paio_pkg.sv ====
// types shared by the port a io block
package paio_pkg;

  // drive of one group of pins: level and output enable
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } paio_pin_drv_t;

  // drive of a single pad
  typedef struct packed {
    logic level;
    logic enable;
  } paio_pad_drv_t;

  // bus handshake phase
  typedef enum logic {
    PAIO_BUS_IDLE,
    PAIO_BUS_ANSWER
  } paio_bus_state_t;

endpackage

// ==== dv/paio_checker.sv ====
// concurrent checks on the port a io block, bound to its ports
module paio_checker
  import paio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  input paio_pin_drv_t port_a_pin_drv,
  input wire logic second_ccp_oe,
  input paio_pad_drv_t pad_c1_drv,
  input paio_pad_drv_t pad_b3_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // taken accesses
  // ----------------
  wire logic wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic rd_take = avs_read && !avs_waitrequest;
  logic ccp_sel;
  // shadow of the ccp route bit, updated on the same edge as the register
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) ccp_sel <= 1'b0;
    else if (wr_take && avs_address == 5'h0C) ccp_sel <= avs_writedata[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(logic [4:0] a);
    wr_take && avs_address == a;
  endsequence
  sequence s_rd(logic [4:0] a);
    rd_take && avs_address == a;
  endsequence
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer");
  // register lands on the taking edge, the pad flop one edge later,
  // so the new drive is first seen two edges after the take
  AST_DIR_INPUT: assert property (s_wr(5'h04) |-> ##2
    port_a_pin_drv.enable == ~$past(avs_writedata[7:0], 2))
    else $error("enable not from direction");
  AST_LATCH_DRIVE: assert property (s_wr(5'h00) |-> ##2
    ((port_a_pin_drv.level ^ $past(avs_writedata[7:0], 2)) &
    port_a_pin_drv.enable) == 8'h00) else $error("driven level not latch");
  AST_ALT_UPPER: assert property (s_rd(5'h0C) |->
    avs_readdata[7:2] == 6'h00) else $error("route upper bits set");
  AST_ANSEL_UPPER: assert property (s_rd(5'h08) |->
    avs_readdata[7:6] == 2'h0) else $error("analog upper bits set");
  AST_UNMAPPED: assert property (rd_take && avs_address > 5'h14 |->
    avs_response == 2'h2 && avs_readdata == 32'h0) else $error("unmapped");
  AST_RESET_DIR: assert property ($rose(rst_b) |->
    port_a_pin_drv.enable == 8'h00) else $error("driver on at reset");
  AST_CCP_ROUTE: assert property ($past(rst_b) |->
    pad_b3_drv.enable == $past(second_ccp_oe && ccp_sel) &&
    pad_c1_drv.enable == $past(second_ccp_oe && !ccp_sel))
    else $error("ccp pad enable wrong");
endmodule

bind paio_port paio_checker i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_response(avs_response),
  .avs_waitrequest(avs_waitrequest), .port_a_pin_drv(port_a_pin_drv),
  .second_ccp_oe(second_ccp_oe), .pad_c1_drv(pad_c1_drv),
  .pad_b3_drv(pad_b3_drv)
);

// ==== dv/paio_pins_model.sv ====
// circuitry wired to the port a pins and the two ccp pads
module paio_pins_model
  import paio_pkg::*;
(
  input wire logic ref_clk,
  input paio_pin_drv_t pin_drv,
  input wire logic [7:0] ext_level,
  input wire logic [7:0] ext_enable,
  input paio_pad_drv_t c1_drv,
  input paio_pad_drv_t b3_drv,
  input wire logic [1:0] ext_pad,
  output logic [7:0] pin_level,
  output logic pad_c1,
  output logic pad_b3
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_pat = 8'h55;
  // floating pins toggle so a stale level is never read back
  always @(posedge ref_clk) float_pat <= ~float_pat;
  wire logic [7:0] ext_val = (ext_enable & ext_level) |
                             (~ext_enable & float_pat);
  // the device driver wins over the weak outside sources
  assign pin_level = (pin_drv.enable & pin_drv.level) |
                     (~pin_drv.enable & ext_val);
  assign pad_c1 = c1_drv.enable ? c1_drv.level : ext_pad[0];
  assign pad_b3 = b3_drv.enable ? b3_drv.level : ext_pad[1];
endmodule

// ==== dv/test_port_a_io_with_pin_steering.sv ====
// register-level tests of the port a io block
module test_port_a_io_with_pin_steering
  import paio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic [7:0] pin_in;
  logic [7:0] ext_level = 8'h00;
  logic [7:0] ext_enable = 8'h00;
  logic [1:0] ext_pad = 2'h0;
  paio_pin_drv_t pin_drv;
  paio_pad_drv_t c1_drv;
  paio_pad_drv_t b3_drv;
  logic pad_c1, pad_b3, ccp_in, ss_b;
  logic ccp_out = 1'b0;
  logic ccp_oe = 1'b0;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_fail = 0;
  int cmp_count = 0;

  initial forever #20 ref_clk = ~ref_clk;

  paio_port i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .port_a_pin_in(pin_in),
    .port_a_pin_drv(pin_drv), .pad_c1_in(pad_c1), .pad_b3_in(pad_b3),
    .pad_c1_drv(c1_drv), .pad_b3_drv(b3_drv), .second_ccp_out(ccp_out),
    .second_ccp_oe(ccp_oe), .second_ccp_in(ccp_in),
    .slave_select_in_b(ss_b)
  );
  paio_pins_model i_pins (
    .ref_clk(ref_clk), .pin_drv(pin_drv), .ext_level(ext_level),
    .ext_enable(ext_enable), .c1_drv(c1_drv), .b3_drv(b3_drv),
    .ext_pad(ext_pad), .pin_level(pin_in), .pad_c1(pad_c1),
    .pad_b3(pad_b3)
  );

  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // one bus access; the request stands until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      close_out;
    end
  endtask

  task rdc(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r);
    acc(1'b0, a, 8'h00);
    chk({rsp, rd}, {r, 24'h000000, e});
  endtask

  // pin changes cross two sync flops and a register before they show
  task wt;
    repeat (6) @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(5'h04, 8'hFF, 2'h0);
    rdc(5'h08, 8'h3F, 2'h0);
    rdc(5'h0C, 8'h00, 2'h0);
    chk(pin_drv.enable, 8'h00);
    ext_enable <= 8'hFF;
    ext_level <= 8'hAA;
    wt;
    rdc(5'h00, 8'h80, 2'h0);
    acc(1'b1, 5'h08, 8'hFF);
    rdc(5'h08, 8'h3F, 2'h0);
    acc(1'b1, 5'h0C, 8'hFF);
    rdc(5'h0C, 8'h03, 2'h0);
    rdc(5'h18, 8'h00, 2'h2);
    acc(1'b1, 5'h08, 8'h00);
    acc(1'b1, 5'h0C, 8'h00);
    rdc(5'h00, 8'hAA, 2'h0);
    acc(1'b1, 5'h00, 8'h35);
    wt;
    rdc(5'h00, 8'hAA, 2'h0);
    acc(1'b1, 5'h04, 8'hF0);
    wt;
    chk(pin_drv.enable, 8'h0F);
    chk(pin_drv.level & 8'h0F, 8'h05);
    rdc(5'h00, 8'hA5, 2'h0);
    acc(1'b1, 5'h10, 8'h02);
    wt;
    rdc(5'h00, 8'hA7, 2'h0);
    acc(1'b1, 5'h14, 8'h01);
    wt;
    rdc(5'h00, 8'hA6, 2'h0);
    // analog on driven pins: drivers stay, input reads zero
    acc(1'b1, 5'h08, 8'h3F);
    wt;
    chk(pin_drv.enable, 8'h0F);
    chk(pin_drv.level & 8'h0F, 8'h06);
    rdc(5'h00, 8'h80, 2'h0);
    // a latch write while driving must reach the pads despite analog
    acc(1'b1, 5'h00, 8'h09);
    wt;
    chk(pin_drv.level & 8'h0F, 8'h09);
    acc(1'b1, 5'h04, 8'hFF);
    acc(1'b1, 5'h08, 8'h00);
    // selected pin low asserts select and high releases it, with the other pin at the opposite level
    for (int r = 0; r < 2; r++) begin
      acc(1'b1, 5'h0C, {6'h00, r[0], 1'b0});
      ext_level <= r[0] ? 8'h20 : 8'h01;
      wt;
      chk(ss_b, 1'b0);
      ext_level <= r[0] ? 8'h01 : 8'h20;
      wt;
      chk(ss_b, 1'b1);
    end
    ccp_oe <= 1'b1;
    ccp_out <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      acc(1'b1, 5'h0C, {7'h00, r[0]});
      wt;
      chk({b3_drv.enable, c1_drv.enable}, r[0] ? 2'b10 : 2'b01);
      chk(r[0] ? b3_drv.level : c1_drv.level, 1'b1);
      chk(ccp_in, 1'b1);
    end
    // pads released: the ccp input follows only the selected pad
    ccp_oe <= 1'b0;
    ext_pad <= 2'h1;
    wt;
    chk(ccp_in, 1'b0);
    acc(1'b1, 5'h0C, 8'h00);
    wt;
    chk(ccp_in, 1'b1);
    close_out;
  end
endmodule
